// ==== verilog/atm_err_cfg.svh ====
`ifndef ATM_ERR_CFG_SVH
`define ATM_ERR_CFG_SVH

// register byte offsets on the plain register port
`define ERR_ADDR_W 8
`define ERR_OFS_CTRL 8'h00
`define ERR_OFS_WATCH 8'h04
`define ERR_OFS_ENABLE 8'h08
`define ERR_OFS_PENDING 8'h0C

// pending / enable bit positions
`define BIT_TX_PRESENT 18
`define BIT_TX_FAILED 17
`define BIT_TX_STALL 16
`define BIT_RX_PRESENT 2
`define BIT_RX_FAILED 1
`define BIT_RX_STALL 0

// control and clock-watch fields
`define BIT_TX_ENABLE 18
`define BIT_RX_ENABLE 2
`define TX_COUNT_LSB 16
`define RX_COUNT_LSB 0
`define COUNT_W 8

// implemented-bit masks and reset values
`define FLAG_MASK 32'h0007_0007
`define CTRL_MASK 32'h0004_0004
`define WATCH_MASK 32'h00FF_00FF
`define WORD_ZERO 32'h0000_0000
`define COUNT_ZERO 8'h00

`endif

// ==== verilog/atm_err_pkg.sv ====
`default_nettype none
package atm_err_pkg;
  typedef logic [31:0] word_t;
  typedef enum {
    SEL_CTRL,
    SEL_WATCH,
    SEL_ENABLE,
    SEL_PENDING,
    SEL_NONE
  } reg_sel_t;
endpackage
`default_nettype wire

// ==== verilog/link_clock_watch.sv ====
`include "atm_err_cfg.svh"
`default_nettype none
module link_clock_watch #(
  parameter int CNT_W = `COUNT_W
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic link_clock_in,
  input wire logic [CNT_W-1:0] limit_in,
  output logic edge_out,
  output logic timeout_out,
  output logic present_out
);
  logic sync_meta;
  logic sync_q;
  logic sync_prev;
  logic [CNT_W:0] gap;
  logic edge_q;
  logic timeout_q;
  logic present;
  logic [CNT_W:0] next_gap;
  logic next_edge;
  logic next_timeout;
  logic next_present;

  // the first flop is read only by the second
  always_comb begin
    next_edge = sync_q & ~sync_prev;
    if (next_edge) begin
      next_gap = '0;
    end else if (&gap) begin
      next_gap = gap;
    end else begin
      next_gap = gap + 1'b1;
    end
    // limit of zero switches detection off
    next_timeout = (limit_in != '0) && !next_edge &&
                   (gap == {1'b0, limit_in});
    next_present = next_edge | (present & ~next_timeout);
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync_meta <= 1'b0;
      sync_q <= 1'b0;
      sync_prev <= 1'b0;
      gap <= '0;
      edge_q <= 1'b0;
      timeout_q <= 1'b0;
      present <= 1'b0;
    end else begin
      sync_meta <= link_clock_in;
      sync_q <= sync_meta;
      sync_prev <= sync_q;
      gap <= next_gap;
      edge_q <= next_edge;
      timeout_q <= next_timeout;
      present <= next_present;
    end
  end

  assign edge_out = edge_q;
  assign timeout_out = timeout_q;
  assign present_out = present;

  gap_reset_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in) edge_q |-> gap == '0)
    else $error("gap counter not cleared by a link edge");
endmodule
`default_nettype wire

// ==== verilog/queue_stall_watch.sv ====
`default_nettype none
module queue_stall_watch (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic req_in,
  input wire logic blocked_in,
  output logic accept_out,
  output logic stall_out
);
  logic stall;
  logic next_stall;

  // a blocked request is held, never forced through
  always_comb begin
    next_stall = req_in & blocked_in;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stall <= 1'b0;
    end else begin
      stall <= next_stall;
    end
  end

  assign accept_out = req_in & ~blocked_in;
  assign stall_out = stall;

  no_accept_blocked_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in) blocked_in |-> !accept_out)
    else $error("request accepted while queue blocked");
endmodule
`default_nettype wire

// ==== verilog/atm_port_error_pending_flags.sv ====
`include "atm_err_cfg.svh"
`default_nettype none
module atm_port_error_pending_flags (
  input wire logic CLOCK_IN,
  input wire logic RST_N_IN,
  input wire logic [`ERR_ADDR_W-1:0] ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [31:0] RDATA_OUT,
  input wire logic TX_LINK_CLOCK_IN,
  input wire logic RX_LINK_CLOCK_IN,
  input wire logic TX_QUEUE_WR_REQ_IN,
  input wire logic TX_QUEUE_FULL_IN,
  output logic TX_QUEUE_WR_ACCEPT_OUT,
  input wire logic RX_QUEUE_RD_REQ_IN,
  input wire logic RX_QUEUE_EMPTY_IN,
  output logic RX_QUEUE_RD_ACCEPT_OUT,
  output logic RX_PORT_RESET_OUT,
  output logic PORT_INTERRUPT_OUT
);
  logic rst_meta;
  logic rst_n;

  atm_err_pkg::word_t port_control_reg;
  atm_err_pkg::word_t clock_watch_reg;
  atm_err_pkg::word_t error_interrupt_enables;
  atm_err_pkg::word_t error_pending_flags;
  atm_err_pkg::word_t rdata;
  atm_err_pkg::word_t next_port_control_reg;
  atm_err_pkg::word_t next_clock_watch_reg;
  atm_err_pkg::word_t next_error_interrupt_enables;
  atm_err_pkg::word_t next_rdata;
  atm_err_pkg::word_t clear_mask;
  atm_err_pkg::reg_sel_t wr_sel;
  atm_err_pkg::reg_sel_t rd_sel;

  logic tx_clock_present_flag;
  logic tx_clock_failed_flag;
  logic rx_clock_present_flag;
  logic rx_clock_failed_flag;
  logic tx_queue_stall_flag;
  logic rx_queue_stall_flag;
  logic next_tx_present;
  logic next_tx_failed;
  logic next_rx_present;
  logic next_rx_failed;
  logic rx_port_reset;
  logic next_rx_port_reset;
  logic port_interrupt_line;
  logic next_port_interrupt_line;

  logic tx_edge;
  logic tx_timeout;
  logic rx_edge;
  logic rx_timeout;
  logic tx_interface_enable;
  logic rx_interface_enable;
  logic [`COUNT_W-1:0] tx_clock_timeout_count;
  logic [`COUNT_W-1:0] rx_clock_timeout_count;

  // one decode shared by the read and the write path
  function automatic atm_err_pkg::reg_sel_t decode_addr(
    input logic [`ERR_ADDR_W-1:0] addr
  );
    atm_err_pkg::reg_sel_t sel;
    case (addr)
      `ERR_OFS_CTRL: sel = atm_err_pkg::SEL_CTRL;
      `ERR_OFS_WATCH: sel = atm_err_pkg::SEL_WATCH;
      `ERR_OFS_ENABLE: sel = atm_err_pkg::SEL_ENABLE;
      `ERR_OFS_PENDING: sel = atm_err_pkg::SEL_PENDING;
      default: sel = atm_err_pkg::SEL_NONE;
    endcase
    return sel;
  endfunction

  // reset is released through two flops, asserted at once
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  assign tx_interface_enable = port_control_reg[`BIT_TX_ENABLE];
  assign rx_interface_enable = port_control_reg[`BIT_RX_ENABLE];
  assign tx_clock_timeout_count =
    clock_watch_reg[`TX_COUNT_LSB +: `COUNT_W];
  assign rx_clock_timeout_count =
    clock_watch_reg[`RX_COUNT_LSB +: `COUNT_W];

  link_clock_watch #(
    .CNT_W(`COUNT_W)
  ) u_tx_watch (
    .clk_in(CLOCK_IN),
    .rst_n_in(rst_n),
    .link_clock_in(TX_LINK_CLOCK_IN),
    .limit_in(tx_clock_timeout_count),
    .edge_out(tx_edge),
    .timeout_out(tx_timeout),
    .present_out()
  );

  link_clock_watch #(
    .CNT_W(`COUNT_W)
  ) u_rx_watch (
    .clk_in(CLOCK_IN),
    .rst_n_in(rst_n),
    .link_clock_in(RX_LINK_CLOCK_IN),
    .limit_in(rx_clock_timeout_count),
    .edge_out(rx_edge),
    .timeout_out(rx_timeout),
    .present_out()
  );

  queue_stall_watch u_tx_stall (
    .clk_in(CLOCK_IN),
    .rst_n_in(rst_n),
    .req_in(TX_QUEUE_WR_REQ_IN),
    .blocked_in(TX_QUEUE_FULL_IN),
    .accept_out(TX_QUEUE_WR_ACCEPT_OUT),
    .stall_out(tx_queue_stall_flag)
  );

  queue_stall_watch u_rx_stall (
    .clk_in(CLOCK_IN),
    .rst_n_in(rst_n),
    .req_in(RX_QUEUE_RD_REQ_IN),
    .blocked_in(RX_QUEUE_EMPTY_IN),
    .accept_out(RX_QUEUE_RD_ACCEPT_OUT),
    .stall_out(rx_queue_stall_flag)
  );

  // software-side registers
  always_comb begin
    wr_sel = decode_addr(ADDR_IN);
    rd_sel = decode_addr(ADDR_IN);
    next_port_control_reg = port_control_reg;
    next_clock_watch_reg = clock_watch_reg;
    next_error_interrupt_enables = error_interrupt_enables;
    clear_mask = `WORD_ZERO;
    if (WR_IN) begin
      case (wr_sel)
        atm_err_pkg::SEL_CTRL:
          next_port_control_reg = WDATA_IN & `CTRL_MASK;
        atm_err_pkg::SEL_WATCH:
          next_clock_watch_reg = WDATA_IN & `WATCH_MASK;
        atm_err_pkg::SEL_ENABLE:
          next_error_interrupt_enables = WDATA_IN & `FLAG_MASK;
        atm_err_pkg::SEL_PENDING:
          clear_mask = WDATA_IN & `FLAG_MASK;
        default: clear_mask = `WORD_ZERO;
      endcase
    end
    next_rdata = `WORD_ZERO;
    if (RD_IN) begin
      case (rd_sel)
        atm_err_pkg::SEL_CTRL: next_rdata = port_control_reg;
        atm_err_pkg::SEL_WATCH: next_rdata = clock_watch_reg;
        atm_err_pkg::SEL_ENABLE: next_rdata = error_interrupt_enables;
        atm_err_pkg::SEL_PENDING: next_rdata = error_pending_flags;
        default: next_rdata = `WORD_ZERO;
      endcase
    end
  end

  // flags: a hardware set wins over a clear in the same cycle
  always_comb begin
    next_tx_present = tx_edge |
      (tx_clock_present_flag & ~clear_mask[`BIT_TX_PRESENT] &
       ~tx_timeout);
    next_rx_present = rx_edge |
      (rx_clock_present_flag & ~clear_mask[`BIT_RX_PRESENT] &
       ~rx_timeout);
    next_tx_failed = (tx_timeout & tx_interface_enable) |
      (tx_clock_failed_flag & ~clear_mask[`BIT_TX_FAILED]);
    next_rx_failed = (rx_timeout & rx_interface_enable) |
      (rx_clock_failed_flag & ~clear_mask[`BIT_RX_FAILED]);
    next_rx_port_reset = rx_timeout & rx_interface_enable;
    // refreshed each cycle from the registered flags and enables
    next_port_interrupt_line =
      |(error_pending_flags & error_interrupt_enables);
  end

  // reserved bits are never stored, so they always read zero
  always_comb begin
    error_pending_flags = `WORD_ZERO;
    error_pending_flags[`BIT_TX_PRESENT] = tx_clock_present_flag;
    error_pending_flags[`BIT_TX_FAILED] = tx_clock_failed_flag;
    error_pending_flags[`BIT_TX_STALL] = tx_queue_stall_flag;
    error_pending_flags[`BIT_RX_PRESENT] = rx_clock_present_flag;
    error_pending_flags[`BIT_RX_FAILED] = rx_clock_failed_flag;
    error_pending_flags[`BIT_RX_STALL] = rx_queue_stall_flag;
  end

  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      port_control_reg <= `WORD_ZERO;
      clock_watch_reg <= `WORD_ZERO;
      error_interrupt_enables <= `WORD_ZERO;
      rdata <= `WORD_ZERO;
      tx_clock_present_flag <= 1'b0;
      tx_clock_failed_flag <= 1'b0;
      rx_clock_present_flag <= 1'b0;
      rx_clock_failed_flag <= 1'b0;
      rx_port_reset <= 1'b0;
      port_interrupt_line <= 1'b0;
    end else begin
      port_control_reg <= next_port_control_reg;
      clock_watch_reg <= next_clock_watch_reg;
      error_interrupt_enables <= next_error_interrupt_enables;
      rdata <= next_rdata;
      tx_clock_present_flag <= next_tx_present;
      tx_clock_failed_flag <= next_tx_failed;
      rx_clock_present_flag <= next_rx_present;
      rx_clock_failed_flag <= next_rx_failed;
      rx_port_reset <= next_rx_port_reset;
      port_interrupt_line <= next_port_interrupt_line;
    end
  end

  assign RDATA_OUT = rdata;
  assign RX_PORT_RESET_OUT = rx_port_reset;
  assign PORT_INTERRUPT_OUT = port_interrupt_line;

  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (!rst_n);
  sequence tx_loss_s;
    tx_timeout && tx_interface_enable;
  endsequence
  sequence rx_loss_s;
    rx_timeout && rx_interface_enable;
  endsequence

  tx_present_tracks_a: assert property (
    tx_edge |=> tx_clock_present_flag)
    else $error("tx present flag missed a link edge");

  tx_absent_clears_a: assert property (
    tx_timeout |=> !tx_clock_present_flag)
    else $error("tx present flag held after clock loss");

  rx_present_tracks_a: assert property (
    rx_edge |=> rx_clock_present_flag)
    else $error("rx present flag missed a link edge");

  tx_fail_gate_a: assert property (
    $rose(tx_clock_failed_flag) |-> $past(tx_interface_enable))
    else $error("tx failed flag set while tx interface off");

  tx_fail_set_a: assert property (
    tx_loss_s |=> tx_clock_failed_flag)
    else $error("tx failed flag not set on clock loss");

  rx_fail_gate_a: assert property (
    $rose(rx_clock_failed_flag) |-> $past(rx_interface_enable))
    else $error("rx failed flag set while rx interface off");

  rx_fail_set_a: assert property (
    rx_loss_s |=> rx_clock_failed_flag)
    else $error("rx failed flag not set on clock loss");

  tx_stall_set_a: assert property (
    TX_QUEUE_WR_REQ_IN && TX_QUEUE_FULL_IN |=>
      tx_queue_stall_flag)
    else $error("tx stall flag not set on write to full queue");

  tx_stall_held_a: assert property (
    TX_QUEUE_FULL_IN |-> !TX_QUEUE_WR_ACCEPT_OUT)
    else $error("write passed into a full tx queue");

  tx_stall_clear_a: assert property (
    tx_queue_stall_flag && !TX_QUEUE_FULL_IN |=> !tx_queue_stall_flag)
    else $error("tx stall flag stuck after space freed");

  rx_stall_set_a: assert property (
    RX_QUEUE_RD_REQ_IN && RX_QUEUE_EMPTY_IN |=>
      rx_queue_stall_flag)
    else $error("rx stall flag not set on read from empty queue");

  rx_stall_clear_a: assert property (
    RX_QUEUE_RD_ACCEPT_OUT |=> !rx_queue_stall_flag)
    else $error("rx stall flag stuck after read completed");

  irq_follow_a: assert property (
    |(error_pending_flags & error_interrupt_enables) |=>
      PORT_INTERRUPT_OUT)
    else $error("interrupt missing for enabled pending flag");

  irq_quiet_a: assert property (
    !(|(error_pending_flags & error_interrupt_enables)) |=>
      !PORT_INTERRUPT_OUT)
    else $error("interrupt raised with nothing enabled pending");

  reserved_zero_a: assert property (
    (error_pending_flags & ~`FLAG_MASK) == `WORD_ZERO)
    else $error("reserved pending bits not zero");

  w1c_clear_a: assert property (
    WR_IN && ADDR_IN == `ERR_OFS_PENDING &&
      WDATA_IN[`BIT_TX_FAILED] && !tx_timeout |=>
      !tx_clock_failed_flag)
    else $error("write of one did not clear tx failed flag");

  count_zero_off_a: assert property (
    rx_clock_timeout_count == `COUNT_ZERO |-> ##1 !rx_timeout)
    else $error("rx loss reported with detection disabled");

  rx_reset_pulse_a: assert property (
    rx_loss_s |=> RX_PORT_RESET_OUT ##1 !RX_PORT_RESET_OUT)
    else $error("rx port reset not a single pulse on clock loss");

  read_timing_a: assert property (
    !RD_IN |=> RDATA_OUT == `WORD_ZERO)
    else $error("read data present without a read strobe");
endmodule
`default_nettype wire

// ==== test/link_clock_source.sv ====
`default_nettype none
module link_clock_source (
  input wire logic tx_run_in,
  input wire logic rx_run_in,
  output logic tx_clock_out,
  output logic rx_clock_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // a stopped clock parks low: a clock left high would hide the lost edge
  // for half a period and blur the timeout figure
  initial begin
    tx_clock_out = 1'b0;
    #3.7;
    forever begin
      #32;
      if (tx_run_in || tx_clock_out) begin
        tx_clock_out = ~tx_clock_out;
      end
    end
  end
  initial begin
    rx_clock_out = 1'b0;
    #17.1;
    forever begin
      #32;
      if (rx_run_in || rx_clock_out) begin
        rx_clock_out = ~rx_clock_out;
      end
    end
  end
endmodule
`default_nettype wire

// ==== test/atm_port_error_pending_flags_bench.sv ====
`include "atm_err_cfg.svh"
`default_nettype none
module atm_port_error_pending_flags_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [`ERR_ADDR_W-1:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic tx_run = 1'b0;
  logic rx_run = 1'b0;
  logic tx_req = 1'b0;
  logic tx_full = 1'b0;
  logic rx_req = 1'b0;
  logic rx_empty = 1'b1;
  logic [31:0] rdata;
  logic tx_clk, rx_clk, tx_acc, rx_acc, rx_port_rst, irq;
  int fail_count = 0;
  int samples_checked = 0;
  int rx_resets = 0;
  int base;

  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    if (rx_port_rst === 1'b1) begin
      rx_resets++;
    end
  end

  link_clock_source far_end (
    .tx_run_in(tx_run),
    .rx_run_in(rx_run),
    .tx_clock_out(tx_clk),
    .rx_clock_out(rx_clk)
  );
  atm_port_error_pending_flags dut (
    .CLOCK_IN(clk),
    .RST_N_IN(rst_n),
    .ADDR_IN(addr),
    .WDATA_IN(wdata),
    .WR_IN(wr),
    .RD_IN(rd),
    .RDATA_OUT(rdata),
    .TX_LINK_CLOCK_IN(tx_clk),
    .RX_LINK_CLOCK_IN(rx_clk),
    .TX_QUEUE_WR_REQ_IN(tx_req),
    .TX_QUEUE_FULL_IN(tx_full),
    .TX_QUEUE_WR_ACCEPT_OUT(tx_acc),
    .RX_QUEUE_RD_REQ_IN(rx_req),
    .RX_QUEUE_EMPTY_IN(rx_empty),
    .RX_QUEUE_RD_ACCEPT_OUT(rx_acc),
    .RX_PORT_RESET_OUT(rx_port_rst),
    .PORT_INTERRUPT_OUT(irq)
  );

  task automatic finish_test();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] e,
      input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, e, s);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic reg_wr(input logic [`ERR_ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [`ERR_ADDR_W-1:0] a,
      output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic expect_reg(input string name, input logic [7:0] a,
      input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    reg_rd(a, d);
    check(name, e, d & m);
  endtask
  // one queue side: masked stall, unmasked stall, release, self clear
  task automatic stall_case(input bit tx_side, input logic [31:0] m);
    reg_wr(`ERR_OFS_ENABLE, 32'h0000_0000);
    @(posedge clk);
    tx_req <= tx_side;
    tx_full <= tx_side;
    rx_req <= !tx_side;
    rx_empty <= 1'b1;
    cycles(3);
    check("accept while blocked", 1'b0, tx_side ? tx_acc : rx_acc);
    check("masked interrupt", 1'b0, irq);
    reg_wr(`ERR_OFS_ENABLE, m);
    cycles(2);
    check("stall interrupt", 1'b1, irq);
    expect_reg("stall flag", `ERR_OFS_PENDING, 32'h0001_0001, m);
    reg_wr(`ERR_OFS_PENDING, `FLAG_MASK);
    expect_reg("stall read only", `ERR_OFS_PENDING, 32'h0001_0001, m);
    @(posedge clk);
    tx_full <= 1'b0;
    rx_empty <= 1'b0;
    #1;
    check("accept on release", 1'b1, tx_side ? tx_acc : rx_acc);
    @(posedge clk);
    tx_req <= 1'b0;
    rx_req <= 1'b0;
    rx_empty <= 1'b1;
    cycles(3);
    expect_reg("stall cleared", `ERR_OFS_PENDING,
      32'h0001_0001, 32'h0);
    check("interrupt dropped", 1'b0, irq);
  endtask

  initial begin
    #50000;
    fail_count++;
    finish_test();
  end

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    cycles(4);
    expect_reg("pending at reset", `ERR_OFS_PENDING,
      32'hFFFF_FFFF, 32'h0);
    reg_wr(`ERR_OFS_ENABLE, 32'hFFFF_FFFF);
    expect_reg("enable bits", `ERR_OFS_ENABLE,
      32'hFFFF_FFFF, `FLAG_MASK);
    cycles(2);
    check("no pending no interrupt", 1'b0, irq);
    reg_wr(`ERR_OFS_ENABLE, 32'h0000_0000);
    reg_wr(8'h10, 32'hFFFF_FFFF);
    expect_reg("unmapped read", 8'h10, 32'hFFFF_FFFF, 32'h0);
    // presence flags with both directions disabled and counts at zero
    tx_run <= 1'b1;
    rx_run <= 1'b1;
    cycles(40);
    expect_reg("present flags", `ERR_OFS_PENDING,
      32'hFFFF_FFFF, 32'h0004_0004);
    cycles(1);
    check("read data one cycle", 32'h0, rdata);
    reg_wr(`ERR_OFS_CTRL, `CTRL_MASK);
    base = rx_resets;
    tx_run <= 1'b0;
    rx_run <= 1'b0;
    cycles(120);
    expect_reg("count zero", `ERR_OFS_PENDING,
      32'hFFFF_FFFF, 32'h0004_0004);
    check("no port reset", base, rx_resets);
    reg_wr(`ERR_OFS_PENDING, 32'h0000_0000);
    expect_reg("write zero", `ERR_OFS_PENDING,
      32'hFFFF_FFFF, 32'h0004_0004);
    reg_wr(`ERR_OFS_PENDING, 32'hFFFF_FFFF);
    expect_reg("write one", `ERR_OFS_PENDING, 32'hFFFF_FFFF, 32'h0);
    // timeout with only the receive direction enabled, then both
    reg_wr(`ERR_OFS_WATCH, 32'h0020_0020);
    for (int pass = 0; pass < 2; pass++) begin
      reg_wr(`ERR_OFS_CTRL, pass ? `CTRL_MASK : 32'h0000_0004);
      tx_run <= 1'b1;
      rx_run <= 1'b1;
      cycles(60);
      expect_reg("running clocks", `ERR_OFS_PENDING,
        `FLAG_MASK, 32'h0004_0004);
      base = rx_resets;
      tx_run <= 1'b0;
      rx_run <= 1'b0;
      cycles(20);
      expect_reg("before count", `ERR_OFS_PENDING,
        `FLAG_MASK, 32'h0004_0004);
      cycles(40);
      expect_reg("after count", `ERR_OFS_PENDING,
        `FLAG_MASK, pass ? 32'h0002_0002 : 32'h0000_0002);
      check("rx port reset", 1'b1, rx_resets > base);
      reg_wr(`ERR_OFS_ENABLE, 32'h0000_0002);
      cycles(2);
      check("failed interrupt", 1'b1, irq);
      reg_wr(`ERR_OFS_ENABLE, 32'h0000_0000);
      cycles(2);
      check("failed masked", 1'b0, irq);
      reg_wr(`ERR_OFS_PENDING, `FLAG_MASK);
      expect_reg("failed cleared", `ERR_OFS_PENDING, `FLAG_MASK, 32'h0);
    end
    reg_wr(`ERR_OFS_CTRL, 32'h0000_0000);
    stall_case(1'b1, 32'h0001_0000);
    stall_case(1'b0, 32'h0000_0001);
    finish_test();
  end
endmodule
`default_nettype wire
